// *** pll_control_lock_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - Select codes 011/100/101 load registers 3-5
// - Lock count forty cleared, five set
// - Window 10 ns cleared, 6 ns set
// - Lock only after full run inside window
// - Power-down bit, registers retained
// - Power-down: counters load, pump off, lock reset
// - Three-state bit floats charge pump
// - Counter reset holds both dividers
// - Boost current until near lock
// - Divider mode 10 resync, 00 off
// - Twelve-bit resync timer count
// - Feedback from oscillator or divider chain
// - Three-bit output divider ratio
// - Mute output until lock
// - Output enable and two-bit level
// - Charge cancellation enable bit
// - Two-bit lock pin mode
// - Reference doubled, divided, optionally halved
// - Select codes 000/001/010 load registers 0-2
// - Double buffer delays divider select
// - Second resync pulse after load realigns
module pll_control_lock_detect
	import pll_ctrl_pkg::*;
(
	input  wire logic              I_CLK,
	input  wire logic              I_RESET,
	input  wire logic [ADDR_W-1:0] I_ADDR,
	input  wire logic [31:0]       I_WDATA,
	input  wire logic              I_WR,
	input  wire logic              I_RD,
	input  wire logic              I_REF_EDGE,
	input  wire logic              I_FB_EDGE,
	input  wire logic              I_TUNE_NEAR,
	output var  logic [31:0]       O_RDATA,
	output var  ctrl_out_t         O_CTRL
);

	regs_t     regs;
	regs_t     next_regs;
	core_t     core;
	core_t     next_core;
	ctrl_out_t next_ctrl;
	logic [31:0] next_rdata;

	logic       pd;
	logic       hold;
	logic [9:0] rdiv;
	logic       ref_rise;
	logic       fb_rise;
	logic       pfd_src;
	logic [5:0] need;
	logic       win_ok;
	logic       wr_load;

	////////////////////////////////////////////////////////////////
	// Field decode

	always_comb
	begin
		pd      = regs.cfg2[F2_PWR_DOWN];
		hold    = pd | regs.cfg2[F2_CNT_RST];
		rdiv    = regs.cfg2[F2_RCOUNT_LSB +: 10];
		ref_rise = core.ref_s2 & ~core.ref_d;
		fb_rise  = core.fb_s2 & ~core.fb_d;
		need    = regs.cfg2[F2_WIN_COUNT] ? LOCK_COUNT_FAST
		                                  : LOCK_COUNT_SLOW;
		win_ok  = core.err <= lock_window(regs.cfg2[F2_WIN_WIDTH]);
		wr_load = I_WR & (I_ADDR <= SEL_R5);
	end

	////////////////////////////////////////////////////////////////
	// Register bank; writes accepted even in power-down

	always_comb
	begin
		next_regs = regs;
		if (wr_load)
		begin
			case (I_WDATA[2:0])
				SEL_R0: next_regs.cfg0 = I_WDATA;
				SEL_R1: next_regs.cfg1 = I_WDATA;
				SEL_R2: next_regs.cfg2 = I_WDATA;
				SEL_R3: next_regs.cfg3 = I_WDATA;
				SEL_R4: next_regs.cfg4 = I_WDATA;
				SEL_R5: next_regs.cfg5 = I_WDATA;
				default: next_regs = regs;
			endcase
		end
		// Buffered divider select follows only on a register 0 load
		if (!regs.cfg2[F2_DBL_BUF])
			next_regs.div4_live = next_regs.cfg4[F4_DIV_LSB +: 3];
		else if (wr_load && I_WDATA[2:0] == SEL_R0)
			next_regs.div4_live = regs.cfg4[F4_DIV_LSB +: 3];
	end

	always_comb
	begin
		next_rdata = 32'h0;
		if (I_RD)
		begin
			case (I_ADDR)
				SEL_R0: next_rdata = regs.cfg0;
				SEL_R1: next_rdata = regs.cfg1;
				SEL_R2: next_rdata = regs.cfg2;
				SEL_R3: next_rdata = regs.cfg3;
				SEL_R4: next_rdata = regs.cfg4;
				SEL_R5: next_rdata = regs.cfg5;
				ADDR_STATUS: next_rdata = {26'h0, core.good_run};
				default: next_rdata = 32'h0;
			endcase
			if (I_ADDR == ADDR_STATUS)
				next_rdata[31] = core.locked;
		end
	end

	////////////////////////////////////////////////////////////////
	// Phase detector clock and lock detector

	always_comb
	begin
		next_core = core;
		next_core.ref_s1 = I_REF_EDGE;
		next_core.ref_s2 = core.ref_s1;
		next_core.ref_d  = core.ref_s2;
		next_core.fb_s1  = I_FB_EDGE;
		next_core.fb_s2  = core.fb_s1;
		next_core.fb_d   = core.fb_s2;
		// Tuning comparator is asynchronous to the clock
		next_core.tune_s1 = I_TUNE_NEAR;
		next_core.tune_s2 = core.tune_s1;
		next_core.pfd_tick = 1'b0;
		next_core.resync   = 1'b0;
		pfd_src = 1'b0;

		// Doubler uses both reference edges, then R, then halver
		if (hold)
		begin
			next_core.rcount = 10'h0;
			next_core.halve  = 1'b0;
		end
		else if (regs.cfg2[F2_DOUBLER] ? (core.ref_s2 != core.ref_d)
		                               : ref_rise)
		begin
			if (core.rcount + 10'h1 >= rdiv)
			begin
				next_core.rcount = 10'h0;
				next_core.halve  = ~core.halve;
				pfd_src = ~regs.cfg2[F2_HALVER] | core.halve;
			end
			else
				next_core.rcount = core.rcount + 10'h1;
		end
		next_core.pfd_tick = pfd_src;

		// Error measured between reference tick and feedback edge
		if (pfd_src)
		begin
			next_core.ref_seen = 1'b1;
			if (fb_rise)
				next_core.err = 8'h0;
		end
		if (fb_rise)
			next_core.fb_seen = 1'b1;
		if (core.ref_seen ^ core.fb_seen)
			// Saturate: a wrap to zero would fake a good cycle
			next_core.err = (core.err >= 8'hf8) ? 8'hff : core.err + 8'h8;
		if (core.ref_seen & core.fb_seen)
		begin
			next_core.ref_seen = pfd_src;
			next_core.fb_seen  = fb_rise & ~pfd_src;
			if (win_ok)
			begin
				if (core.good_run + 6'h1 >= need)
				begin
					next_core.good_run = need;
					next_core.locked   = 1'b1;
				end
				else
					next_core.good_run = core.good_run + 6'h1;
			end
			else
			begin
				next_core.good_run = 6'h0;
				next_core.locked   = 1'b0;
			end
			next_core.err = 8'h0;
		end
		if (pd)
		begin
			next_core.good_run = 6'h0;
			next_core.locked   = 1'b0;
			next_core.ref_seen = 1'b0;
			next_core.fb_seen  = 1'b0;
			next_core.err      = 8'h0;
		end

		// Resync timer: interval x modulus phase-detector ticks
		if (regs.cfg3[F3_DIVMODE_LSB +: 2] != DIVMODE_RESYNC || hold)
		begin
			next_core.resync_div = 12'h0;
			next_core.resync_mod = 12'h0;
		end
		else if (pfd_src)
		begin
			if (core.resync_mod + 12'h1 >= regs.cfg1[F1_MOD_LSB +: 12])
			begin
				next_core.resync_mod = 12'h0;
				if (core.resync_div + 12'h1 >=
				    regs.cfg3[F3_INTERVAL_LSB +: 12])
				begin
					next_core.resync_div = 12'h0;
					if (core.resync_pend == 2'h1)
						next_core.resync = 1'b1;
					if (core.resync_pend != 2'h0)
						next_core.resync_pend = core.resync_pend - 2'h1;
				end
				else
					next_core.resync_div = core.resync_div + 12'h1;
			end
			else
				next_core.resync_mod = core.resync_mod + 12'h1;
		end
		// New frequency load arms the second timer pulse
		if (wr_load && I_WDATA[2:0] == SEL_R0)
			next_core.resync_pend = 2'h2;
	end

	////////////////////////////////////////////////////////////////
	// Analog control outputs

	always_comb
	begin
		next_ctrl.cp_hiz    = pd | regs.cfg2[F2_CP_3STATE];
		next_ctrl.boost     = regs.cfg3[F3_BOOST] & ~core.tune_s2
		                    & ~pd;
		next_ctrl.cnt_hold  = hold;
		next_ctrl.out_on    = regs.cfg4[F4_OUT_EN] & ~pd
		                    & ~(regs.cfg4[F4_MUTE] & ~core.locked);
		next_ctrl.out_level = regs.cfg4[F4_PWR_LSB +: 2];
		next_ctrl.out_div   = regs.div4_live;
		next_ctrl.fb_direct = regs.cfg4[F4_FB_SEL];
		next_ctrl.chg_cancel = regs.cfg5[F5_CHG_CANCEL];
		case (regs.cfg5[F5_LDPIN_LSB +: 2])
			LDPIN_LOW:      next_ctrl.lock_pin = 1'b0;
			LDPIN_DIG_LOCK: next_ctrl.lock_pin = core.locked;
			LDPIN_HIGH:     next_ctrl.lock_pin = 1'b1;
			default:        next_ctrl.lock_pin = 1'b0;
		endcase
		next_ctrl.mux_out = (regs.cfg2[F2_MUX_LSB +: 3] == MUX_DIG_LOCK)
		                  & core.locked;
		next_ctrl.resync  = core.resync;
		next_ctrl.pfd_clk = core.pfd_tick;
	end

	////////////////////////////////////////////////////////////////

	always_ff @(posedge I_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			regs    <= '0;
			core    <= '0;
			O_CTRL  <= '0;
			O_RDATA <= 32'h0;
		end
		else
		begin
			regs    <= next_regs;
			core    <= next_core;
			O_CTRL  <= next_ctrl;
			O_RDATA <= next_rdata;
		end
	end

endmodule : pll_control_lock_detect
`default_nettype wire

// *** pll_ctrl_pkg.sv ***
package pll_ctrl_pkg;

	// Register select codes held in the three low bits of a word
	localparam logic [2:0] SEL_R0 = 3'h0;
	localparam logic [2:0] SEL_R1 = 3'h1;
	localparam logic [2:0] SEL_R2 = 3'h2;
	localparam logic [2:0] SEL_R3 = 3'h3;
	localparam logic [2:0] SEL_R4 = 3'h4;
	localparam logic [2:0] SEL_R5 = 3'h5;

	// Register bank port: word index is the register select code
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_STATUS = 3'h7;

	// Field positions, register 1
	localparam int F1_MOD_LSB   = 3;
	// Field positions, register 2
	localparam int F2_CNT_RST   = 3;
	localparam int F2_CP_3STATE = 4;
	localparam int F2_PWR_DOWN  = 5;
	localparam int F2_WIN_WIDTH = 7;
	localparam int F2_WIN_COUNT = 8;
	localparam int F2_DBL_BUF   = 13;
	localparam int F2_RCOUNT_LSB = 14;
	localparam int F2_HALVER    = 24;
	localparam int F2_DOUBLER   = 25;
	localparam int F2_MUX_LSB   = 26;
	// Field positions, register 3
	localparam int F3_INTERVAL_LSB = 3;
	localparam int F3_DIVMODE_LSB  = 15;
	localparam int F3_BOOST        = 18;
	// Field positions, register 4
	localparam int F4_PWR_LSB   = 3;
	localparam int F4_OUT_EN    = 5;
	localparam int F4_MUTE      = 10;
	localparam int F4_DIV_LSB   = 20;
	localparam int F4_FB_SEL    = 23;
	// Field positions, register 5
	localparam int F5_LDPIN_LSB = 22;
	localparam int F5_CHG_CANCEL = 29;
	localparam int F5_ABL_LSB   = 30;

	localparam logic [1:0] DIVMODE_OFF    = 2'h0;
	localparam logic [1:0] DIVMODE_RESYNC = 2'h2;
	localparam logic [2:0] MUX_DIG_LOCK   = 3'h6;
	localparam logic [1:0] LDPIN_LOW      = 2'h0;
	localparam logic [1:0] LDPIN_DIG_LOCK = 2'h1;
	localparam logic [1:0] LDPIN_HIGH     = 2'h3;

	localparam logic [5:0] LOCK_COUNT_SLOW = 6'h28;
	localparam logic [5:0] LOCK_COUNT_FAST = 6'h05;
	// Phase-error windows in ps, converted to eighths of 25 ns clock cycles (round down)
	localparam int CLK_PERIOD_PS = 25000;
	localparam int WIN_WIDE_PS   = 10000;
	localparam int WIN_NARROW_PS = 6000;
	localparam int WIN_WIDE_CYC_I = (WIN_WIDE_PS * 8) / CLK_PERIOD_PS;
	localparam int WIN_NARROW_CYC_I = (WIN_NARROW_PS * 8) / CLK_PERIOD_PS;
	// Error measured in eighth-cycles from two-flop sampled edges
	localparam logic [7:0] WIN_WIDE_E8   = 8'(WIN_WIDE_CYC_I);
	localparam logic [7:0] WIN_NARROW_E8 = 8'(WIN_NARROW_CYC_I);

	localparam logic [31:0] REG_RESET = 32'h0;

	typedef struct packed {
		logic [31:0] cfg0;
		logic [31:0] cfg1;
		logic [31:0] cfg2;
		logic [31:0] cfg3;
		logic [31:0] cfg4;
		logic [31:0] cfg5;
		logic [2:0]  div4_live;
	} regs_t;

	typedef struct packed {
		logic        ref_s1;
		logic        ref_s2;
		logic        ref_d;
		logic        fb_s1;
		logic        fb_s2;
		logic        fb_d;
		logic        ref_seen;
		logic        fb_seen;
		logic [7:0]  err;
		logic        pfd_tick;
		logic [9:0]  rcount;
		logic        halve;
		logic [5:0]  good_run;
		logic        locked;
		logic [11:0] resync_div;
		logic [11:0] resync_mod;
		logic [1:0]  resync_pend;
		logic        resync;
		logic        tune_s1;
		logic        tune_s2;
	} core_t;

	typedef struct packed {
		logic        cp_hiz;
		logic        boost;
		logic        cnt_hold;
		logic        out_on;
		logic [1:0]  out_level;
		logic [2:0]  out_div;
		logic        fb_direct;
		logic        chg_cancel;
		logic        lock_pin;
		logic        mux_out;
		logic        resync;
		logic        pfd_clk;
	} ctrl_out_t;

	function automatic logic [7:0] lock_window(input logic narrow);
		lock_window = narrow ? WIN_NARROW_E8 : WIN_WIDE_E8;
	endfunction : lock_window

endpackage : pll_ctrl_pkg

// *** pll_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_chk
	import pll_ctrl_pkg::*;
(
	input  wire logic              I_CLK,
	input  wire logic              I_RESET,
	input  wire logic [ADDR_W-1:0] I_ADDR,
	input  wire logic [31:0]       I_WDATA,
	input  wire logic              I_WR,
	input  wire ctrl_out_t         O_CTRL
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);

	logic       ok;
	logic       w2;
	logic       w3;
	logic       w4;
	logic       w5;
	logic       pd_q;
	logic       dbl_q;
	logic [1:0] mode_q;

	assign ok = I_WR && (I_ADDR <= 3'h5);
	assign w2 = ok && (I_WDATA[2:0] == SEL_R2);
	assign w3 = ok && (I_WDATA[2:0] == SEL_R3);
	assign w4 = ok && (I_WDATA[2:0] == SEL_R4);
	assign w5 = ok && (I_WDATA[2:0] == SEL_R5);

	// Shadows of the few bits that qualify later checks
	always_ff @(posedge I_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			pd_q   <= 1'b0;
			dbl_q  <= 1'b0;
			mode_q <= 2'h0;
		end
		else
		begin
			if (w2)
			begin
				pd_q  <= I_WDATA[F2_PWR_DOWN];
				dbl_q <= I_WDATA[F2_DBL_BUF];
			end
			if (w3)
				mode_q <= I_WDATA[F3_DIVMODE_LSB+:2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	pd_forces_a: assert property (w2 && I_WDATA[F2_PWR_DOWN] |-> ##2
		O_CTRL.cp_hiz && O_CTRL.cnt_hold && !O_CTRL.out_on)
		else $error("power-down write did not force outputs");
	pd_hold_a: assert property (pd_q && $past(pd_q) |->
		O_CTRL.cp_hiz && !O_CTRL.out_on)
		else $error("outputs active while powered down");
	pump_float_a: assert property (w2 && I_WDATA[F2_CP_3STATE] |->
		##2 O_CTRL.cp_hiz) else $error("pump not floated");
	cnt_hold_a: assert property (w2 && I_WDATA[F2_CNT_RST] |->
		##2 O_CTRL.cnt_hold) else $error("counters not held");
	fb_select_a: assert property (w4 |-> ##2
		O_CTRL.fb_direct == $past(I_WDATA[F4_FB_SEL], 2))
		else $error("feedback select mismatch");
	out_level_a: assert property (w4 |-> ##2
		O_CTRL.out_level == $past(I_WDATA[F4_PWR_LSB+:2], 2))
		else $error("output level mismatch");
	out_div_a: assert property (w4 && !dbl_q |-> ##2
		O_CTRL.out_div == $past(I_WDATA[F4_DIV_LSB+:3], 2))
		else $error("divider select mismatch");
	cancel_bit_a: assert property (w5 |-> ##2
		O_CTRL.chg_cancel == $past(I_WDATA[F5_CHG_CANCEL], 2))
		else $error("charge cancel mismatch");
	pin_fixed_a: assert property (w5 &&
		I_WDATA[F5_LDPIN_LSB+:2] != LDPIN_DIG_LOCK |-> ##2
		O_CTRL.lock_pin == ($past(I_WDATA[F5_LDPIN_LSB+:2], 2) == LDPIN_HIGH))
		else $error("lock pin fixed level mismatch");
	resync_mode_a: assert property (O_CTRL.resync |->
		mode_q == DIVMODE_RESYNC || $past(mode_q, 3) == DIVMODE_RESYNC)
		else $error("resync pulse with divider mode off");

	cover property ($rose(O_CTRL.lock_pin));
	cover property (O_CTRL.resync);
	cover property (pd_q && $past(pd_q));
endmodule : pll_ctrl_chk

bind pll_control_lock_detect pll_ctrl_chk i_chk (.I_CLK(I_CLK),
	.I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.O_CTRL(O_CTRL));
`default_nettype wire

// *** pll_loop_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_loop_model
(
	input  wire logic i_clk,
	input  wire logic i_lag,
	output var  logic o_ref,
	output var  logic o_fb
);
	logic [1:0] cnt = 2'h0;

	initial o_ref = 1'b0;
	initial o_fb = 1'b0;

	// One clock of lag is far outside both windows; none is dead on
	always @(posedge i_clk)
	begin
		cnt <= cnt + 2'h1;
		o_ref <= cnt[1];
		o_fb <= i_lag ? o_ref : cnt[1];
	end
endmodule : pll_loop_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
	import pll_ctrl_pkg::*;
;
	logic        I_CLK;
	logic        I_RESET;
	logic [2:0]  I_ADDR;
	logic [31:0] I_WDATA;
	logic        I_WR;
	logic        I_RD;
	logic        I_REF_EDGE;
	logic        I_FB_EDGE;
	logic        I_TUNE_NEAR;
	logic        lag;
	logic [31:0] O_RDATA;
	ctrl_out_t   O_CTRL;
	int          miscompares = 0;
	int          comparisons = 0;
	int          n;
	int          k;
	int          c;
	logic [31:0] r2v [4] = '{32'h18004182, 32'h1800c182, 32'h1a004182,
		32'h19008182};
	int          per [4] = '{4, 12, 2, 16};

	initial
	begin
		I_CLK = 1'b0;
		forever #12.5 I_CLK = ~I_CLK;
	end

	pll_control_lock_detect i_dut (.I_CLK(I_CLK), .I_RESET(I_RESET),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
		.I_REF_EDGE(I_REF_EDGE), .I_FB_EDGE(I_FB_EDGE),
		.I_TUNE_NEAR(I_TUNE_NEAR), .O_RDATA(O_RDATA), .O_CTRL(O_CTRL));
	pll_loop_model i_loop (.i_clk(I_CLK), .i_lag(lag), .o_ref(I_REF_EDGE),
		.o_fb(I_FB_EDGE));

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %h, want %h at %0t", got, exp, $time);
		end
	endtask : chk

	task automatic wr(input logic [31:0] d);
		@(posedge I_CLK);
		I_ADDR <= d[2:0];
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask : wr

	task automatic settle;
		repeat (2) @(posedge I_CLK);
		#1;
	endtask : settle

	task automatic give_up;
		miscompares++;
		$display("unexpected timeout at %0t", $time);
		end_sim;
	endtask : give_up

	task automatic rd(input logic [2:0] a, input logic [31:0] exp);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1;
		chk(O_RDATA, exp);
	endtask : rd

	task automatic wait_pfd(output int cyc);
		cyc = 0;
		do
		begin
			@(posedge I_CLK);
			#1;
			cyc++;
		end
		while (O_CTRL.pfd_clk !== 1'b1 && cyc < 300);
		if (cyc >= 300)
			give_up;
	endtask : wait_pfd

	// Muted output must stay off until the run of good cycles completes
	task automatic lock_run(input int want);
		int j;
		@(posedge I_CLK);
		lag <= 1'b1;
		repeat (40) @(posedge I_CLK);
		#1;
		chk(O_CTRL.out_on, 1'b0);
		lag = 1'b0;
		j = 0;
		while (O_CTRL.lock_pin !== 1'b1 && j < 60)
		begin
			wait_pfd(c);
			j++;
		end
		if (O_CTRL.lock_pin !== 1'b1)
			give_up;
		chk(j >= want && j <= want + 3, 1'b1);
		chk(O_CTRL.out_on, 1'b1);
	endtask : lock_run

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		I_RESET = 1'b1;
		I_ADDR = 3'h0;
		I_WDATA = 32'h0;
		I_WR = 1'b0;
		I_RD = 1'b0;
		I_TUNE_NEAR = 1'b0;
		lag = 1'b1;
		repeat (2) @(posedge I_CLK);
		I_RESET <= 1'b0;
		wr(32'h00400005);
		wr(32'h00a00434);
		wr(32'h00000003);
		wr(32'h18004182);
		wr(32'h00000009);
		wr(32'h00000000);
		settle;
		chk(O_CTRL.fb_direct, 1'b1);
		chk(O_CTRL.out_div, 3'h2);
		chk(O_CTRL.out_level, 2'h2);
		rd(3'h4, 32'h00a00434);
		lock_run(5);
		chk(O_CTRL.mux_out, 1'b1);
		rd(3'h7, 32'h80000005);
		wr(32'h00a00414);
		settle;
		chk(O_CTRL.out_on, 1'b0);
		wr(32'h00a00434);
		settle;
		chk(O_CTRL.out_on, 1'b1);
		for (k = 0; k < 4; k++)
		begin
			wr(32'h00000005 | (k << 22));
			settle;
			chk(O_CTRL.lock_pin, k[0]);
		end
		wr(32'h00400005);
		settle;
		chk(O_CTRL.lock_pin, 1'b1);
		@(posedge I_CLK);
		lag <= 1'b1;
		repeat (3) wait_pfd(c);
		chk(O_CTRL.lock_pin, 1'b0);
		chk(O_CTRL.mux_out, 1'b0);
		wr(32'h18004082);
		lock_run(40);
		wr(32'h180040a2);
		settle;
		chk({O_CTRL.cp_hiz, O_CTRL.cnt_hold, O_CTRL.out_on}, 3'h6);
		chk(O_CTRL.lock_pin, 1'b0);
		wr(32'h00040003);
		rd(3'h3, 32'h00040003);
		rd(3'h2, 32'h180040a2);
		wr(32'h18004082);
		settle;
		chk(O_CTRL.cp_hiz, 1'b0);
		chk(O_CTRL.boost, 1'b1);
		@(posedge I_CLK);
		I_TUNE_NEAR <= 1'b1;
		settle;
		settle;
		chk(O_CTRL.boost, 1'b0);
		wr(32'h1800409a);
		settle;
		chk({O_CTRL.cp_hiz, O_CTRL.cnt_hold}, 2'h3);
		wr(32'h18006082);
		wr(32'h00d00434);
		settle;
		chk(O_CTRL.out_div, 3'h2);
		wr(32'h00000000);
		settle;
		chk(O_CTRL.out_div, 3'h5);
		wr(32'h20400005);
		settle;
		chk(O_CTRL.chg_cancel, 1'b1);
		for (k = 0; k < 4; k++)
		begin
			wr(r2v[k]);
			repeat (2) wait_pfd(c);
			wait_pfd(c);
			chk(c, per[k]);
		end
		wr(32'h00010013);
		wr(32'h00000000);
		n = 0;
		k = 0;
		while (O_CTRL.resync !== 1'b1 && n < 400)
		begin
			@(posedge I_CLK);
			#1;
			n++;
			k += O_CTRL.pfd_clk;
		end
		if (O_CTRL.resync !== 1'b1)
			give_up;
		chk(k >= 2 && k <= 5, 1'b1);
		wr(32'h00000013);
		repeat (10) @(posedge I_CLK);
		n = 0;
		repeat (100)
		begin
			@(posedge I_CLK);
			#1;
			n += O_CTRL.resync;
		end
		chk(n, 0);
		end_sim;
	end
endmodule : tb
`default_nettype wire
